// [verilog/ccr_pkg.sv]
/*
 * Charger configuration register bank: shared constants and the current decode function.
 * Assumes an 8-bit register port driven by the serial management bus controller.
 */
package ccr_pkg;

   // ************************************************************
   // Register offsets
   // ************************************************************
   localparam logic [7:0] CCR_ADDR_PREQ_TERM = 8'h22;
   localparam logic [7:0] CCR_ADDR_DIE_SYS   = 8'h23;
   localparam logic [7:0] CCR_ADDR_FAST_TMR  = 8'h24;
   localparam logic [7:0] CCR_ADDR_ALT_THM   = 8'h25;

   // ************************************************************
   // Reset values, per field
   // ************************************************************
   localparam logic [2:0] CCR_RST_PREQUAL  = 3'h7;
   localparam logic [1:0] CCR_RST_TERM     = 2'h3;
   localparam logic [2:0] CCR_RST_TOPOFF   = 3'h0;
   localparam logic [2:0] CCR_RST_DIE_TEMP = 3'h0;
   localparam logic [4:0] CCR_RST_SYS_V    = 5'h10;
   localparam logic [5:0] CCR_RST_FAST_CC  = 6'h01;
   localparam logic [1:0] CCR_RST_SAFETY   = 2'h1;
   localparam logic [5:0] CCR_RST_ALT_CC   = 6'h00;
   localparam logic       CCR_RST_THM_ON   = 1'b0;

   // ************************************************************
   // Decode constants (mV, 0.1 mA, 0.1 %, minutes, degC, hours)
   // ************************************************************
   localparam logic [11:0] CCR_PQ_BASE_MV   = 12'h8FC;  // 2300 mV
   localparam logic [11:0] CCR_PQ_STEP_MV   = 12'h064;  // 100 mV
   localparam logic [12:0] CCR_SYS_BASE_MV  = 13'h1004; // 4100 mV
   localparam logic [12:0] CCR_SYS_STEP_MV  = 13'h0019; // 25 mV
   localparam logic [11:0] CCR_CC_STEP_DMA  = 12'h04B;  // 7.5 mA
   localparam logic [5:0]  CCR_CC_MAX_CODE  = 6'h27;    // 300 mA and above
   localparam logic [5:0]  CCR_TOPOFF_STEP  = 6'h05;    // 5 minutes
   localparam logic [6:0]  CCR_TJ_BASE_C    = 7'h3C;    // 60 degC
   localparam logic [6:0]  CCR_TJ_STEP_C    = 7'h0A;    // 10 degC
   localparam logic [2:0]  CCR_TJ_MAX_CODE  = 3'h4;     // 100 degC and above
   localparam logic [7:0]  CCR_TERM_05      = 8'h32;
   localparam logic [7:0]  CCR_TERM_075     = 8'h4B;
   localparam logic [7:0]  CCR_TERM_10      = 8'h64;
   localparam logic [7:0]  CCR_TERM_15      = 8'h96;
   localparam logic [2:0]  CCR_SAFE_OFF_H   = 3'h0;
   localparam logic [2:0]  CCR_SAFE_3_H     = 3'h3;
   localparam logic [2:0]  CCR_SAFE_5_H     = 3'h5;
   localparam logic [2:0]  CCR_SAFE_7_H     = 3'h7;

   // ************************************************************
   // Types
   // ************************************************************
   typedef enum logic [1:0] {
      CCR_ZONE_NORMAL = 2'h0,
      CCR_ZONE_COOL   = 2'h1,
      CCR_ZONE_WARM   = 2'h3,
      CCR_ZONE_OUT    = 2'h2
   } ccr_zone_t;

   // Linear 7.5 mA code, saturating at 300 mA
   function automatic logic [11:0] ccr_current_dma(input logic [5:0] code);
      logic [5:0] sat;
      sat = (code > CCR_CC_MAX_CODE) ? CCR_CC_MAX_CODE : code;
      return 12'({6'h00, sat} + 12'h001) * CCR_CC_STEP_DMA;
   endfunction

endpackage

// [verilog/ccr_current_select.sv]
/*
 * Picks the charge current code for the present battery temperature zone.
 * Assumes zone is already synchronous and valid when thermistor monitoring is on.
 */
`timescale 1ns/100ps
module ccr_current_select
   import ccr_pkg::*;
(
   input  wire logic [5:0]  fast_charge_current_sel,
   input  wire logic [5:0]  alt_zone_charge_current_sel,
   input  wire logic        thermistor_monitor_on,
   input  wire ccr_zone_t   batt_zone,
   output logic      [5:0]  active_current_sel,
   output logic             alt_in_use
);

   // ************************************************************
   // Zone selection
   // ************************************************************
   // Without monitoring the zone is unknown, so the normal current is the safe pick
   always_comb begin
      alt_in_use = thermistor_monitor_on &&
                   (batt_zone == CCR_ZONE_COOL || batt_zone == CCR_ZONE_WARM);
      active_current_sel = alt_in_use ? alt_zone_charge_current_sel
                                      : fast_charge_current_sel;
   end

endmodule

// [verilog/ccr_field_decode.sv]
/*
 * Turns the timing and temperature codes into engineering values.
 * Purely combinational; the caller registers the results.
 */
`timescale 1ns/100ps
module ccr_field_decode
   import ccr_pkg::*;
(
   input  wire logic [2:0]  topoff_time_sel,
   input  wire logic [2:0]  die_temp_regulation_sel,
   input  wire logic [1:0]  fast_charge_safety_timer,
   input  wire logic [1:0]  term_current_sel,
   output logic      [5:0]  topoff_minutes,
   output logic      [6:0]  die_temp_c,
   output logic      [2:0]  safety_hours,
   output logic      [7:0]  term_permille
);

   logic [2:0] tj_sat;

   always_comb begin
      topoff_minutes = 6'({3'h0, topoff_time_sel} * CCR_TOPOFF_STEP);
      tj_sat = (die_temp_regulation_sel > CCR_TJ_MAX_CODE) ? CCR_TJ_MAX_CODE
                                                          : die_temp_regulation_sel;
      die_temp_c = 7'(CCR_TJ_BASE_C + {4'h0, tj_sat} * CCR_TJ_STEP_C);
      unique case (fast_charge_safety_timer)
         2'h0:    safety_hours = CCR_SAFE_OFF_H;
         2'h1:    safety_hours = CCR_SAFE_3_H;
         2'h2:    safety_hours = CCR_SAFE_5_H;
         2'h3:    safety_hours = CCR_SAFE_7_H;
      endcase
      unique case (term_current_sel)
         2'h0:    term_permille = CCR_TERM_05;
         2'h1:    term_permille = CCR_TERM_075;
         2'h2:    term_permille = CCR_TERM_10;
         2'h3:    term_permille = CCR_TERM_15;
      endcase
   end

endmodule

// [verilog/ccr_config_regs.sv]
/*
 * Charger configuration register bank: four byte registers at 0x22..0x25,
 * field outputs and registered decoded values for the charging loop.
 * Assumes the serial bus controller presents single-cycle read and write
 * strobes with a byte address, synchronous to clk.
 */
// Operation
// - Prequal threshold bits 7:5, resets 0b111
// - Termination current bits 4:3, resets 0b11
// - Top-off timer bits 2:0, 5-minute steps
// - Die temperature point bits 7:5, saturates 100C
// - System voltage 4:0, 4.1V plus 25mV
// - Fast current 7:2, 7.5mA steps, saturates
// - Safety timer 1:0, off/3/5/7 hours
// - Alternate current used in cool/warm zones
// - Normal zone uses standard fast current
// - Thermistor enable bit 1, resets zero
`timescale 1ns/100ps
module ccr_config_regs
   import ccr_pkg::*;
(
   input  wire logic         clk,
   input  wire logic         sys_rst,
   input  wire logic [7:0]   reg_addr,
   input  wire logic         reg_wr,
   input  wire logic [7:0]   reg_wdata,
   input  wire logic         reg_rd,
   output logic      [7:0]   reg_rdata,
   output logic              reg_rvalid,
   output logic              reg_hit,
   input  wire ccr_zone_t    batt_zone,
   output logic      [2:0]   prequal_voltage_sel,
   output logic      [1:0]   term_current_sel,
   output logic      [2:0]   topoff_time_sel,
   output logic      [2:0]   die_temp_regulation_sel,
   output logic      [4:0]   system_voltage_sel,
   output logic      [5:0]   fast_charge_current_sel,
   output logic      [1:0]   fast_charge_safety_timer,
   output logic      [5:0]   alt_zone_charge_current_sel,
   output logic              thermistor_monitor_on,
   output logic      [11:0]  prequal_mv,
   output logic      [7:0]   term_permille,
   output logic      [5:0]   topoff_minutes,
   output logic      [6:0]   die_temp_c,
   output logic      [12:0]  system_mv,
   output logic      [2:0]   safety_hours,
   output logic      [5:0]   active_current_sel,
   output logic      [11:0]  active_current_dma,
   output logic              alt_current_active
);

   // ************************************************************
   // Address decode
   // ************************************************************
   logic        sel_preq;
   logic        sel_die;
   logic        sel_fast;
   logic        sel_alt;
   logic        sel_any;
   logic [7:0]  next_rdata;

   always_comb begin
      sel_preq = (reg_addr == CCR_ADDR_PREQ_TERM);
      sel_die  = (reg_addr == CCR_ADDR_DIE_SYS);
      sel_fast = (reg_addr == CCR_ADDR_FAST_TMR);
      sel_alt  = (reg_addr == CCR_ADDR_ALT_THM);
      sel_any  = sel_preq | sel_die | sel_fast | sel_alt;
   end

   // ************************************************************
   // Register storage
   // ************************************************************
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         prequal_voltage_sel <= CCR_RST_PREQUAL;
         term_current_sel    <= CCR_RST_TERM;
         topoff_time_sel     <= CCR_RST_TOPOFF;
      end else if (reg_wr && sel_preq) begin
         prequal_voltage_sel <= reg_wdata[7:5];
         term_current_sel    <= reg_wdata[4:3];
         topoff_time_sel     <= reg_wdata[2:0];
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         die_temp_regulation_sel <= CCR_RST_DIE_TEMP;
         system_voltage_sel      <= CCR_RST_SYS_V;
      end else if (reg_wr && sel_die) begin
         die_temp_regulation_sel <= reg_wdata[7:5];
         // Any code is stored; checking headroom against charge voltage is host work
         system_voltage_sel      <= reg_wdata[4:0];
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         fast_charge_current_sel  <= CCR_RST_FAST_CC;
         fast_charge_safety_timer <= CCR_RST_SAFETY;
      end else if (reg_wr && sel_fast) begin
         fast_charge_current_sel  <= reg_wdata[7:2];
         fast_charge_safety_timer <= reg_wdata[1:0];
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         alt_zone_charge_current_sel <= CCR_RST_ALT_CC;
         thermistor_monitor_on       <= CCR_RST_THM_ON;
      end else if (reg_wr && sel_alt) begin
         alt_zone_charge_current_sel <= reg_wdata[7:2];
         thermistor_monitor_on       <= reg_wdata[1];
      end
   end

   // ************************************************************
   // Read back
   // ************************************************************
   // Data lags the strobe by one cycle; unmapped addresses answer 0x00
   always_comb begin
      next_rdata = 8'h00;
      if (sel_preq) begin
         next_rdata = {prequal_voltage_sel, term_current_sel, topoff_time_sel};
      end else if (sel_die) begin
         next_rdata = {die_temp_regulation_sel, system_voltage_sel};
      end else if (sel_fast) begin
         next_rdata = {fast_charge_current_sel, fast_charge_safety_timer};
      end else if (sel_alt) begin
         next_rdata = {alt_zone_charge_current_sel, thermistor_monitor_on, 1'b0};
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         reg_rdata  <= 8'h00;
         reg_rvalid <= 1'b0;
         reg_hit    <= 1'b0;
      end else begin
         reg_rvalid <= reg_rd;
         reg_hit    <= (reg_rd | reg_wr) & sel_any;
         if (reg_rd) begin
            reg_rdata <= next_rdata;
         end
      end
   end

   // ************************************************************
   // Decoded values for the charging loop
   // ************************************************************
   logic [5:0]  dec_topoff;
   logic [6:0]  dec_die_temp;
   logic [2:0]  dec_safety;
   logic [7:0]  dec_term;
   logic [5:0]  sel_current;
   logic        sel_alt_used;

   ccr_field_decode u_decode (
      .topoff_time_sel         (topoff_time_sel),
      .die_temp_regulation_sel (die_temp_regulation_sel),
      .fast_charge_safety_timer(fast_charge_safety_timer),
      .term_current_sel        (term_current_sel),
      .topoff_minutes          (dec_topoff),
      .die_temp_c              (dec_die_temp),
      .safety_hours            (dec_safety),
      .term_permille           (dec_term)
   );

   ccr_current_select u_current (
      .fast_charge_current_sel    (fast_charge_current_sel),
      .alt_zone_charge_current_sel(alt_zone_charge_current_sel),
      .thermistor_monitor_on      (thermistor_monitor_on),
      .batt_zone                  (batt_zone),
      .active_current_sel         (sel_current),
      .alt_in_use                 (sel_alt_used)
   );

   // Decoded values trail the fields by one cycle so every output is a flop
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         prequal_mv     <= CCR_PQ_BASE_MV;
         term_permille  <= CCR_TERM_05;
         topoff_minutes <= 6'h00;
         die_temp_c     <= CCR_TJ_BASE_C;
         system_mv      <= CCR_SYS_BASE_MV;
         safety_hours   <= CCR_SAFE_OFF_H;
      end else begin
         prequal_mv     <= 12'(CCR_PQ_BASE_MV + {9'h000, prequal_voltage_sel}
                                                 * CCR_PQ_STEP_MV);
         term_permille  <= dec_term;
         topoff_minutes <= dec_topoff;
         die_temp_c     <= dec_die_temp;
         system_mv      <= 13'(CCR_SYS_BASE_MV + {8'h00, system_voltage_sel}
                                                  * CCR_SYS_STEP_MV);
         safety_hours   <= dec_safety;
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         active_current_sel <= 6'h00;
         active_current_dma <= CCR_CC_STEP_DMA;
         alt_current_active <= 1'b0;
      end else begin
         active_current_sel <= sel_current;
         active_current_dma <= ccr_current_dma(sel_current);
         alt_current_active <= sel_alt_used;
      end
   end

endmodule

// [tb/ccr_host_model.sv]
/* Host side of the configuration register port: byte reads and writes.
   Assumes single-cycle strobes sampled on the rising edge of clk. */
`timescale 1ns/100ps
module ccr_host_model (
   input  wire logic       clk,
   output logic      [7:0] reg_addr,
   output logic            reg_wr,
   output logic      [7:0] reg_wdata,
   output logic            reg_rd,
   input  wire logic [7:0] reg_rdata,
   input  wire logic       reg_rvalid,
   input  wire logic       reg_hit
);
   initial begin
      reg_addr <= 8'h00;
      reg_wr <= 1'b0;
      reg_wdata <= 8'h00;
      reg_rd <= 1'b0;
   end
   // Caller keeps system voltage headroom above charge voltage
   task automatic wr(input logic [7:0] a, input logic [7:0] dat);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= dat;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
      // Released lines flip so stale values never look valid
      reg_addr <= ~a;
      reg_wdata <= ~dat;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] dat, output logic v, h);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      reg_addr <= ~a;
      #1;
      dat = reg_rdata;
      v = reg_rvalid;
      h = reg_hit;
   endtask
endmodule

// [tb/ccr_config_checker.sv]
/* Concurrent checks on the register bank ports.
   Assumes binding to ccr_config_regs; one clock, reset active high. */
`timescale 1ns/100ps
module ccr_config_checker
   import ccr_pkg::*;
(
   input wire logic        clk,
   input wire logic        sys_rst,
   input wire logic [7:0]  reg_addr,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [7:0]  reg_rdata,
   input wire logic        reg_rvalid,
   input wire logic        reg_hit,
   input wire ccr_zone_t   batt_zone,
   input wire logic [2:0]  prequal_voltage_sel,
   input wire logic [2:0]  die_temp_regulation_sel,
   input wire logic [4:0]  system_voltage_sel,
   input wire logic [5:0]  fast_charge_current_sel,
   input wire logic [1:0]  fast_charge_safety_timer,
   input wire logic [5:0]  alt_zone_charge_current_sel,
   input wire logic        thermistor_monitor_on,
   input wire logic [11:0] prequal_mv,
   input wire logic [6:0]  die_temp_c,
   input wire logic [12:0] system_mv,
   input wire logic [2:0]  safety_hours,
   input wire logic [5:0]  active_current_sel,
   input wire logic [11:0] active_current_dma
);
   logic mapped;
   assign mapped = (reg_addr >= 8'h22) && (reg_addr <= 8'h25);
   logic armed;
   // Decoded outputs hold reset constants for one edge after release
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         armed <= 1'b0;
      end else begin
         armed <= 1'b1;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   property p_rvalid; reg_rd |=> reg_rvalid; endproperty
   a_rvalid: assert property (p_rvalid) else $error("read valid missing");
   property p_hit; 1 |=> reg_hit == ($past(reg_rd || reg_wr) && $past(mapped)); endproperty
   a_hit: assert property (p_hit) else $error("hit flag wrong");
   property p_unmapped; reg_rd && !mapped |=> reg_rdata == 8'h00; endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   property p_spare; reg_rd && !reg_wr && reg_addr == 8'h25 |=>
      reg_rdata == {alt_zone_charge_current_sel, thermistor_monitor_on, 1'b0}; endproperty
   a_spare: assert property (p_spare) else $error("alt register readback");
   property p_pq; armed |=> prequal_mv == 12'h8FC + 12'h064 * $past(prequal_voltage_sel);
   endproperty
   a_pq: assert property (p_pq) else $error("prequal decode");
   property p_die; armed |=> die_temp_c == ($past(die_temp_regulation_sel) > 3'h3 ? 7'h64 :
      7'h3C + 7'h0A * $past(die_temp_regulation_sel)); endproperty
   a_die: assert property (p_die) else $error("die temperature decode");
   property p_sys; armed |=> system_mv == 13'h1004 + 13'h0019 * $past(system_voltage_sel);
   endproperty
   a_sys: assert property (p_sys) else $error("system voltage decode");
   property p_safe; armed |=> safety_hours == ($past(fast_charge_safety_timer) == 2'h0 ? 3'h0 :
      {$past(fast_charge_safety_timer), 1'b1}); endproperty
   a_safe: assert property (p_safe) else $error("safety timer decode");
   property p_zone; armed |=> active_current_sel == ($past(thermistor_monitor_on) &&
      ($past(batt_zone) inside {CCR_ZONE_COOL, CCR_ZONE_WARM}) ?
      $past(alt_zone_charge_current_sel) : $past(fast_charge_current_sel)); endproperty
   a_zone: assert property (p_zone) else $error("zone current select");
   property p_dma; 1 |-> active_current_dma == 12'h04B *
      (12'(active_current_sel > 6'h27 ? 6'h27 : active_current_sel) + 12'h001); endproperty
   a_dma: assert property (p_dma) else $error("current decode");
   c_alt: cover property (active_current_sel != fast_charge_current_sel);
   c_unmapped: cover property (reg_rd && !mapped);
   c_write: cover property (reg_wr && mapped);
endmodule
bind ccr_config_regs ccr_config_checker u_chk (
   .clk                         (clk),
   .sys_rst                     (sys_rst),
   .reg_addr                    (reg_addr),
   .reg_wr                      (reg_wr),
   .reg_rd                      (reg_rd),
   .reg_rdata                   (reg_rdata),
   .reg_rvalid                  (reg_rvalid),
   .reg_hit                     (reg_hit),
   .batt_zone                   (batt_zone),
   .prequal_voltage_sel         (prequal_voltage_sel),
   .die_temp_regulation_sel     (die_temp_regulation_sel),
   .system_voltage_sel          (system_voltage_sel),
   .fast_charge_current_sel     (fast_charge_current_sel),
   .fast_charge_safety_timer    (fast_charge_safety_timer),
   .alt_zone_charge_current_sel (alt_zone_charge_current_sel),
   .thermistor_monitor_on       (thermistor_monitor_on),
   .prequal_mv                  (prequal_mv),
   .die_temp_c                  (die_temp_c),
   .system_mv                   (system_mv),
   .safety_hours                (safety_hours),
   .active_current_sel          (active_current_sel),
   .active_current_dma          (active_current_dma)
);

// [tb/ccr_config_regs_bench.sv]
/* Self-checking bench for the charger configuration register bank.
   Assumes the host model drives the register port and the bench the zone. */
`timescale 1ns/100ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin fails++; \
   $display("[FAIL] %0t got %h expected %h", $time, g, e); end end
module ccr_config_regs_bench;
   import ccr_pkg::*;
   logic        clk = 1'b0;
   logic        sys_rst = 1'b1;
   logic [7:0]  reg_addr, reg_wdata, reg_rdata, term_permille, d;
   logic        reg_wr, reg_rd, reg_rvalid, reg_hit, thermistor_monitor_on, alt_current_active;
   logic        v, h;
   logic [2:0]  prequal_voltage_sel, topoff_time_sel, die_temp_regulation_sel, safety_hours;
   logic [1:0]  term_current_sel, fast_charge_safety_timer;
   logic [4:0]  system_voltage_sel;
   logic [5:0]  fast_charge_current_sel, alt_zone_charge_current_sel, topoff_minutes;
   logic [5:0]  active_current_sel;
   logic [11:0] prequal_mv, active_current_dma;
   logic [6:0]  die_temp_c;
   logic [12:0] system_mv;
   ccr_zone_t   batt_zone = CCR_ZONE_NORMAL;
   int          fails = 0;
   int          comparisons = 0;
   logic [7:0]  term_tab [4] = '{8'h32, 8'h4B, 8'h64, 8'h96};
   logic [2:0]  hrs_tab [4] = '{3'h0, 3'h3, 3'h5, 3'h7};
   ccr_config_regs DUT (
      .clk                         (clk),
      .sys_rst                     (sys_rst),
      .reg_addr                    (reg_addr),
      .reg_wr                      (reg_wr),
      .reg_wdata                   (reg_wdata),
      .reg_rd                      (reg_rd),
      .reg_rdata                   (reg_rdata),
      .reg_rvalid                  (reg_rvalid),
      .reg_hit                     (reg_hit),
      .batt_zone                   (batt_zone),
      .prequal_voltage_sel         (prequal_voltage_sel),
      .term_current_sel            (term_current_sel),
      .topoff_time_sel             (topoff_time_sel),
      .die_temp_regulation_sel     (die_temp_regulation_sel),
      .system_voltage_sel          (system_voltage_sel),
      .fast_charge_current_sel     (fast_charge_current_sel),
      .fast_charge_safety_timer    (fast_charge_safety_timer),
      .alt_zone_charge_current_sel (alt_zone_charge_current_sel),
      .thermistor_monitor_on       (thermistor_monitor_on),
      .prequal_mv                  (prequal_mv),
      .term_permille               (term_permille),
      .topoff_minutes              (topoff_minutes),
      .die_temp_c                  (die_temp_c),
      .system_mv                   (system_mv),
      .safety_hours                (safety_hours),
      .active_current_sel          (active_current_sel),
      .active_current_dma          (active_current_dma),
      .alt_current_active          (alt_current_active)
   );
   ccr_host_model host (
      .clk        (clk),
      .reg_addr   (reg_addr),
      .reg_wr     (reg_wr),
      .reg_wdata  (reg_wdata),
      .reg_rd     (reg_rd),
      .reg_rdata  (reg_rdata),
      .reg_rvalid (reg_rvalid),
      .reg_hit    (reg_hit)
   );
   always #25 clk = ~clk;
   task automatic results;
      $display("fails %0d comparisons %0d", fails, comparisons);
      if (fails == 0 && comparisons > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e, input logic hit);
      host.rd(a, d, v, h);
      `CHK({v, h, d}, {1'b1, hit, e})
   endtask
   task automatic settle;
      @(posedge clk);
      #1;
   endtask
   task automatic t_reset;
      rd_chk(8'h22, 8'hF8, 1'b1);
      rd_chk(8'h23, 8'h10, 1'b1);
      rd_chk(8'h24, 8'h05, 1'b1);
      rd_chk(8'h25, 8'h00, 1'b1);
      `CHK({prequal_mv, term_permille, system_mv}, {12'hBB8, 8'h96, 13'h1194})
      `CHK({safety_hours, active_current_dma}, {3'h3, 12'h096})
      $display("test reset done");
   endtask
   task automatic t_access;
      host.wr(8'h25, 8'hFF);
      rd_chk(8'h25, 8'hFE, 1'b1);
      host.wr(8'h21, 8'hA5);
      rd_chk(8'h21, 8'h00, 1'b0);
      rd_chk(8'h22, 8'hF8, 1'b1);
      rd_chk(8'h26, 8'h00, 1'b0);
      host.wr(8'h25, 8'h00);
      $display("test access done");
   endtask
   task automatic t_codes;
      int cc;
      for (int c = 0; c < 8; c++) begin
         cc = c * 6 + 3;
         host.wr(8'h22, {3'(c), 2'(c), 3'(7 - c)});
         host.wr(8'h23, {3'(c), 5'(c * 4 + 3)});
         host.wr(8'h24, {6'(cc), 2'(c)});
         settle();
         `CHK(prequal_mv, 12'h8FC + 12'h064 * 12'(c))
         `CHK(term_permille, term_tab[c % 4])
         `CHK(topoff_minutes, 6'h05 * 6'(7 - c))
         `CHK(die_temp_c, c > 3 ? 7'h64 : 7'h3C + 7'h0A * 7'(c))
         `CHK(system_mv, 13'h1004 + 13'h0019 * 13'(c * 4 + 3))
         `CHK(active_current_dma, 12'h04B * 12'((cc > 8'h27 ? 8'h27 : cc) + 8'h01))
         `CHK(safety_hours, hrs_tab[c % 4])
         rd_chk(8'h22, {3'(c), 2'(c), 3'(7 - c)}, 1'b1);
         rd_chk(8'h23, {3'(c), 5'(c * 4 + 3)}, 1'b1);
         rd_chk(8'h24, {6'(cc), 2'(c)}, 1'b1);
      end
      $display("test codes done");
   endtask
   task automatic t_zone;
      logic alt;
      host.wr(8'h24, 8'h40);
      for (int t = 0; t < 2; t++) begin
         host.wr(8'h25, {6'h20, 1'(t), 1'b0});
         for (int z = 0; z < 4; z++) begin
            @(posedge clk);
            batt_zone <= ccr_zone_t'(z);
            settle();
            alt = (t == 1) && (z == 1 || z == 3);
            `CHK({alt_current_active, active_current_sel}, {alt, alt ? 6'h20 : 6'h10})
         end
      end
      $display("test zone done");
   endtask
   initial begin
      repeat (2000) @(posedge clk);
      fails++;
      results();
   end
   initial begin
      repeat (16) @(posedge clk);
      sys_rst <= 1'b0;
      t_reset();
      t_access();
      t_codes();
      t_zone();
      results();
   end
endmodule
